// file: logic/crm_pkg.sv
package crm_pkg;
    // Command encoding taken from the sampled select, row, column and write-enable pins.
    typedef enum logic [3:0] {
        CRM_CMD_MRS = 4'h0,
        CRM_CMD_REF = 4'h1,
        CRM_CMD_PRE = 4'h2,
        CRM_CMD_ACT = 4'h3,
        CRM_CMD_WR = 4'h4,
        CRM_CMD_ZQC = 4'h6,
        CRM_CMD_RD = 4'h5,
        CRM_CMD_NOP = 4'h7,
        CRM_CMD_DES = 4'h8
    } crm_cmd_t;

    localparam int CRM_ADDR_W = 14;
    localparam int CRM_BANK_W = 3;
    localparam int CRM_DQ_W = 8;
    localparam int CRM_BEATS = 8;
    localparam logic [2:0] CRM_MR3_BANK = 3'h3;
    localparam int CRM_ENABLE_BIT = 2;
    localparam int CRM_LOC_LSB = 0;
    localparam int CRM_COL_HALF_BIT = 2;
    localparam int CRM_AUTO_PRE_BIT = 10;
    localparam int CRM_CHOP_BIT = 12;
    localparam logic [1:0] CRM_LOC_PATTERN = 2'h0;
    localparam logic [1:0] CRM_LOC_RESET = 2'h0;
    localparam logic CRM_ENABLE_RESET = 1'b0;
    localparam logic [7:0] CRM_PATTERN = 8'hAA;
    // Read latency in link clock cycles from a read command to its first data beat.
    localparam int CRM_READ_LATENCY = 5;
    localparam int CRM_LAT_W = 4;
    // Link timing limits, in link clock cycles, system clock cycles or time units as printed.
    localparam int CRM_ODT_HIGH_LONG_BURST_CK = 6;
    localparam int CRM_LEVEL_FIRST_STROBE_CK = 40;
    localparam int CRM_LEVEL_STROBE_DRIVE_CK = 25;
    localparam int CRM_REFRESH_CYCLE_NS = 260;
    localparam int CRM_REFRESH_INTERVAL_NORMAL_NS = 7800;
    localparam int CRM_REFRESH_INTERVAL_HOT_NS = 3900;
    localparam int CRM_CLK_PERIOD_PS = 4000;
    localparam int CRM_REFRESH_CYCLE_CLK = (CRM_REFRESH_CYCLE_NS * 1000 + CRM_CLK_PERIOD_PS - 1)
        / CRM_CLK_PERIOD_PS;
endpackage

// file: logic/crm_cmd_sample.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the link pins plus edge detection of the link clock.
module crm_cmd_sample (
    input wire logic clk,
    input wire logic rst,
    input wire logic ck_link,
    input wire logic [crm_pkg::CRM_ADDR_W+crm_pkg::CRM_BANK_W+4:0] pins_in,
    output logic ck_rise,
    output logic ck_fall,
    output logic [crm_pkg::CRM_ADDR_W+crm_pkg::CRM_BANK_W+4:0] pins_q
);
    import crm_pkg::*;
    localparam int W = CRM_ADDR_W + CRM_BANK_W + 5;

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic ck_meta_q;
    logic ck_sync_q;
    logic ck_prev_q;

    always_ff @(posedge clk) begin
        meta_q <= pins_in;
        sync_q <= meta_q;
        ck_meta_q <= ck_link;
        ck_sync_q <= ck_meta_q;
        if (rst) begin
            // Held high in reset so a link clock already high at release is not seen as a rise.
            ck_prev_q <= 1'b1;
            pins_q <= '0;
        end else begin
            ck_prev_q <= ck_sync_q;
            pins_q <= sync_q;
        end
    end

    assign ck_rise = ck_sync_q && !ck_prev_q;
    assign ck_fall = !ck_sync_q && ck_prev_q;
endmodule

// file: logic/crm_core.sv
`timescale 1ns/1ps
// How it works
// - With the mode on, every read is served from the calibration register.
// - The two-bit location field picks what each calibration read returns.
// - With the mode on, read with auto precharge acts as plain read; no precharge follows.
// - Reset still works while calibration readout is on.
// - Enable clear: location ignored, reads and writes go to the array.
// - Location zero returns 0,1,0,1 beats; chopped reads start at column 0 or 4.
// - Calibration bit on data line zero; other lines copy it.
// - Calibration reads keep normal read latency; loop must be locked first.
module crm_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic ck_link,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [crm_pkg::CRM_BANK_W-1:0] bank,
    input wire logic [crm_pkg::CRM_ADDR_W-1:0] addr,
    input wire logic [crm_pkg::CRM_DQ_W-1:0] array_rdata,
    output logic array_rd,
    output logic array_wr,
    output logic array_pre,
    output logic [crm_pkg::CRM_DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic cal_mode,
    output logic [1:0] loc_field,
    output logic illegal_cmd,
    output logic refresh_early
);
    import crm_pkg::*;
    localparam int PW = CRM_ADDR_W + CRM_BANK_W + 5;

    function automatic crm_cmd_t decode(input logic c, input logic r, input logic a,
                                        input logic w);
        if (c) begin
            decode = CRM_CMD_DES;
        end else begin
            decode = crm_cmd_t'({1'b0, r, a, w});
        end
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic ck_rise;
    logic [PW-1:0] pins_q;

    crm_cmd_sample u_sample (
        .clk(clk),
        .rst(rst),
        .ck_link(ck_link),
        .pins_in({cs_n, ras_n, cas_n, we_n, odt, bank, addr}),
        .ck_rise(ck_rise),
        .ck_fall(),
        .pins_q(pins_q)
    );

    logic s_cs_n;
    logic s_ras_n;
    logic s_cas_n;
    logic s_we_n;
    logic s_odt;
    logic [CRM_BANK_W-1:0] s_bank;
    logic [CRM_ADDR_W-1:0] s_addr;
    crm_cmd_t cmd;

    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt, s_bank, s_addr} = pins_q;
    assign cmd = decode(s_cs_n, s_ras_n, s_cas_n, s_we_n);

    // ------------------------------------------------------------
    // Mode register three
    // ------------------------------------------------------------
    logic cal_en_q;
    logic [1:0] loc_q;
    logic mr3_write;

    assign mr3_write = ck_rise && cmd == CRM_CMD_MRS && s_bank == CRM_MR3_BANK;

    always_ff @(posedge clk) begin
        if (rst) begin
            cal_en_q <= CRM_ENABLE_RESET;
            loc_q <= CRM_LOC_RESET;
        end else if (mr3_write) begin
            cal_en_q <= s_addr[CRM_ENABLE_BIT];
            loc_q <= s_addr[CRM_LOC_LSB+1:CRM_LOC_LSB];
        end
    end

    assign cal_mode = cal_en_q;
    assign loc_field = loc_q;

    // ------------------------------------------------------------
    // Command routing
    // ------------------------------------------------------------
    logic is_read;
    logic is_write;

    assign is_read = ck_rise && cmd == CRM_CMD_RD;
    assign is_write = ck_rise && cmd == CRM_CMD_WR;

    // Array strobes are registered so they line up with the sampled command.
    always_ff @(posedge clk) begin
        if (rst) begin
            array_rd <= 1'b0;
            array_wr <= 1'b0;
            array_pre <= 1'b0;
        end else begin
            array_rd <= is_read && !cal_en_q;
            array_wr <= is_write && !cal_en_q;
            // Auto precharge is dropped while calibration readout owns the reads.
            array_pre <= is_read && !cal_en_q && s_addr[CRM_AUTO_PRE_BIT];
        end
    end

    // Anything but a read, deselect, no-op or register three write while enabled is flagged, not executed.
    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_cmd <= 1'b0;
        end else begin
            illegal_cmd <= ck_rise && cal_en_q && cmd != CRM_CMD_RD && cmd != CRM_CMD_NOP
                && cmd != CRM_CMD_DES && !(cmd == CRM_CMD_MRS && s_bank == CRM_MR3_BANK);
        end
    end

    // ------------------------------------------------------------
    // Refresh spacing watch
    // ------------------------------------------------------------
    logic [15:0] ref_cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_cnt_q <= 16'(CRM_REFRESH_CYCLE_CLK);
            refresh_early <= 1'b0;
        end else begin
            refresh_early <= ck_rise && (cmd == CRM_CMD_REF || cmd == CRM_CMD_ACT)
                && ref_cnt_q < 16'(CRM_REFRESH_CYCLE_CLK);
            if (ck_rise && cmd == CRM_CMD_REF) begin
                ref_cnt_q <= 16'h0000;
            end else if (ref_cnt_q < 16'(CRM_REFRESH_CYCLE_CLK)) begin
                ref_cnt_q <= ref_cnt_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    // A read is remembered as a single pending countdown of link cycles, so the calibration
    // burst appears at the same latency as an array read.
    logic [CRM_LAT_W-1:0] lat_q;
    logic pend_q;
    logic pend_cal_q;
    logic pend_chop_q;
    logic pend_half_q;
    logic [3:0] beat_q;
    logic burst_q;
    logic burst_cal_q;
    logic [3:0] beat_end_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 1'b0;
            pend_cal_q <= 1'b0;
            pend_chop_q <= 1'b0;
            pend_half_q <= 1'b0;
            lat_q <= '0;
        end else if (is_read) begin
            pend_q <= 1'b1;
            pend_cal_q <= cal_en_q;
            pend_chop_q <= !s_addr[CRM_CHOP_BIT];
            pend_half_q <= s_addr[CRM_COL_HALF_BIT];
            lat_q <= CRM_LAT_W'(CRM_READ_LATENCY - 1);
        end else if (pend_q && ck_rise) begin
            if (lat_q == '0) begin
                pend_q <= 1'b0;
            end else begin
                lat_q <= lat_q - 1'b1;
            end
        end
    end

    // One beat per system clock cycle once the burst starts; the link clock does not pace the beats.
    always_ff @(posedge clk) begin
        if (rst) begin
            burst_q <= 1'b0;
            burst_cal_q <= 1'b0;
            beat_q <= 4'h0;
            beat_end_q <= 4'h0;
        end else if (pend_q && ck_rise && lat_q == '0) begin
            burst_q <= 1'b1;
            burst_cal_q <= pend_cal_q;
            beat_q <= pend_chop_q && pend_half_q ? 4'h4 : 4'h0;
            beat_end_q <= pend_chop_q ? (pend_half_q ? 4'h7 : 4'h3) : 4'h7;
        end else if (burst_q) begin
            if (beat_q == beat_end_q) begin
                burst_q <= 1'b0;
            end else begin
                beat_q <= beat_q + 4'h1;
            end
        end
    end

    logic cal_bit;
    assign cal_bit = loc_q == CRM_LOC_PATTERN ? CRM_PATTERN[beat_q[2:0]] : 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            dq_oe <= burst_q;
            if (burst_q && burst_cal_q) begin
                dq_out <= {CRM_DQ_W{cal_bit}};
            end else if (burst_q) begin
                dq_out <= array_rdata;
            end else begin
                dq_out <= '0;
            end
        end
    end
endmodule

// file: dv/crm_core_props.sv
`timescale 1ns/1ps
module crm_core_props (
    input logic clk,
    input logic rst,
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic [crm_pkg::CRM_BANK_W-1:0] bank,
    input logic [crm_pkg::CRM_ADDR_W-1:0] addr,
    input logic array_rd,
    input logic array_wr,
    input logic array_pre,
    input logic [crm_pkg::CRM_DQ_W-1:0] dq_out,
    input logic dq_oe,
    input logic cal_mode,
    input logic [1:0] loc_field
);
    import crm_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic mrs3;
    // Link pins stay put for a whole link cycle, so they still show the cause.
    assign mrs3 = !cs_n && !ras_n && !cas_n && !we_n && bank == CRM_MR3_BANK;
    AST_CAL_NO_ARRAY: assert property (cal_mode |-> !array_rd && !array_wr)
        else $error("array touched in calibration mode");
    AST_NO_PRE: assert property (array_pre |-> array_rd && !cal_mode)
        else $error("precharge without plain array read");
    AST_RST_CLEAR: assert property (disable iff (1'b0) rst |=> !cal_mode && !dq_oe)
        else $error("reset did not clear mode");
    AST_MODE_SRC: assert property ($changed({cal_mode, loc_field}) |-> mrs3)
        else $error("mode changed without register three write");
    AST_MODE_VAL: assert property ($changed({cal_mode, loc_field}) |-> {cal_mode, loc_field} == addr[2:0])
        else $error("mode value differs from address");
    AST_ARRAY_RD: assert property (array_rd |-> !cs_n && ras_n && !cas_n && we_n)
        else $error("array read without read command");
    AST_PAT_ALT: assert property (dq_oe && $past(dq_oe) && cal_mode && loc_field == CRM_LOC_PATTERN
        |-> dq_out == ~$past(dq_out))
        else $error("pattern beats do not alternate");
    AST_PAT_LINES: assert property (dq_oe && cal_mode |-> dq_out == 8'h00 || dq_out == 8'hFF)
        else $error("data lines disagree");
    AST_BURST: assert property ($rose(dq_oe) |-> dq_oe[*4] ##[1:5] !dq_oe)
        else $error("burst length wrong");
endmodule

// file: dv/crm_ctrl_model.sv
`timescale 1ns/1ps
module crm_ctrl_model (
    input logic clk,
    output logic ck_link,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic odt,
    output logic [2:0] bank,
    output logic [13:0] addr
);
    // No activate or leveling is ever issued, so banks stay idle.
    // Writes are chopped, so termination is never needed.
    initial begin
        ck_link = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        odt = 1'b0;
        bank = 3'h0;
        addr = 14'h0;
        #7.3;
        forever #80 ck_link = ~ck_link;
    end
    // One command owns a whole link cycle; idle pins show the inverse so stale values never pass.
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge ck_link);
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = c;
        bank = b;
        addr = a;
        @(negedge ck_link);
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        bank = ~b;
        addr = ~a;
    endtask
    // The same command in two link cycles back to back; used to break refresh spacing on purpose.
    task automatic send_pair(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge ck_link);
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = c;
        bank = b;
        addr = a;
        repeat (2) @(negedge ck_link);
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        bank = ~b;
        addr = ~a;
    endtask
endmodule

// file: dv/crm_core_tb.sv
`timescale 1ns/1ps
module crm_core_tb;
    import crm_pkg::*;
    typedef struct packed {
        logic [13:0] mrs;
        logic [13:0] rd;
    } crm_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ck_link, cs_n, ras_n, cas_n, we_n, odt;
    logic [2:0] bank;
    logic [13:0] addr;
    logic [7:0] array_rdata = 8'h5C;
    logic array_rd, array_wr, array_pre, dq_oe, cal_mode, illegal_cmd, refresh_early;
    logic [7:0] dq_out;
    logic [1:0] loc_field;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n_rd = 0;
    int n_pre = 0;
    int n_wr = 0;
    int n_ill = 0;
    int n_early = 0;
    crm_row_t rows [7] = '{'{14'h0004, 14'h1000}, '{14'h0004, 14'h0000},
        '{14'h0004, 14'h0004}, '{14'h0004, 14'h1400}, '{14'h0005, 14'h1000},
        '{14'h0007, 14'h0000}, '{14'h0003, 14'h1400}};
    crm_ctrl_model u_crm_ctrl_model (.clk, .ck_link, .cs_n, .ras_n, .cas_n, .we_n, .odt,
        .bank, .addr);
    crm_core u_crm_core (.clk, .rst, .ck_link, .cs_n, .ras_n, .cas_n, .we_n, .odt, .bank,
        .addr, .array_rdata, .array_rd, .array_wr, .array_pre, .dq_out, .dq_oe, .cal_mode,
        .loc_field, .illegal_cmd, .refresh_early);
    always #2 clk = ~clk;
    // A full run needs about 3100 cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles++;
        n_rd += array_rd;
        n_pre += array_pre;
        n_wr += array_wr;
        n_ill += illegal_cmd;
        n_early += refresh_early;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_read(input logic [13:0] a, input logic cal, input logic [1:0] loc);
        int k;
        int st;
        n_rd = 0;
        n_pre = 0;
        u_crm_ctrl_model.send(4'h5, 3'h0, a);
        k = 0;
        while (dq_oe !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        st = a[12] ? 0 : (a[2] ? 4 : 0);
        k = 0;
        while (dq_oe === 1'b1 && k < 12) begin
            check("beat", !cal ? array_rdata : (loc != 2'h0 ? 8'h00 : {8{CRM_PATTERN[st + k]}}), dq_out);
            k++;
            tick();
        end
        check("beats", a[12] ? 8'h08 : 8'h04, k[7:0]);
        check("array_rd", {7'h0, !cal}, n_rd[7:0]);
        check("array_pre", {7'h0, !cal && a[10]}, n_pre[7:0]);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // Table of mode writes and reads, then the awkward cases
    // ----
    initial begin
        repeat (20) tick();
        rst = 1'b0;
        check("reset", 8'h00, {cal_mode, loc_field, dq_oe, array_rd, array_wr, array_pre, 1'b0});
        foreach (rows[i]) begin
            u_crm_ctrl_model.send(4'h0, CRM_MR3_BANK, rows[i].mrs);
            check("cal_mode", {7'h0, rows[i].mrs[2]}, {7'h0, cal_mode});
            check("loc_field", {6'h0, rows[i].mrs[1:0]}, {6'h0, loc_field});
            run_read(rows[i].rd, rows[i].mrs[2], rows[i].mrs[1:0]);
        end
        u_crm_ctrl_model.send(4'h0, 3'h2, 14'h0004);
        check("wrong bank", 8'h00, {7'h0, cal_mode});
        n_wr = 0;
        u_crm_ctrl_model.send(4'h4, 3'h0, 14'h0000);
        check("array_wr", 8'h01, n_wr[7:0]);
        u_crm_ctrl_model.send(4'h0, CRM_MR3_BANK, 14'h0004);
        check("mode before reset", 8'h01, {7'h0, cal_mode});
        rst = 1'b1;
        repeat (4) tick();
        rst = 1'b0;
        check("reset in mode", 8'h00, {5'h0, cal_mode, loc_field});
        run_read(14'h1000, 1'b0, 2'h0);
        // A write while the mode is on must be flagged and kept from the array.
        u_crm_ctrl_model.send(4'h0, CRM_MR3_BANK, 14'h0004);
        n_wr = 0;
        n_ill = 0;
        u_crm_ctrl_model.send(4'h4, 3'h0, 14'h0000);
        check("array_wr in mode", 8'h00, n_wr[7:0]);
        check("illegal_cmd", 8'h01, n_ill[7:0]);
        u_crm_ctrl_model.send(4'h0, CRM_MR3_BANK, 14'h0000);
        check("mode cleared", 8'h00, {7'h0, cal_mode});
        // Two refreshes one link cycle apart: only the second falls inside the window.
        n_early = 0;
        n_ill = 0;
        u_crm_ctrl_model.send_pair(4'h1, 3'h0, 14'h0000);
        check("refresh_early", 8'h01, n_early[7:0]);
        check("illegal_cmd off", 8'h00, n_ill[7:0]);
        tally_and_finish();
    end
endmodule
bind crm_core crm_core_props u_crm_core_props (.clk, .rst, .cs_n, .ras_n, .cas_n, .we_n,
    .bank, .addr, .array_rd, .array_wr, .array_pre, .dq_out, .dq_oe, .cal_mode, .loc_field);
